// [gwel_cfg_if.sv]
// Link between the pin bank control and its configuration store
`timescale 1ns/1ps
interface gwel_cfg_if;
    logic wr;
    logic [5:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [47:0][7:0] cfg_all;
    modport mem (input wr, input idx, input wdata, output rdata, output cfg_all);
    modport ctl (output wr, output idx, output wdata, input rdata, input cfg_all);
endinterface

// [gwel_cfg_mem.sv]
// Per-pin configuration store with registered host read data
`timescale 1ns/1ps
module gwel_cfg_mem #(
    parameter int DEPTH = 48
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    gwel_cfg_if.mem bus
);
    import gwel_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] cells;
        logic [7:0] rdata;
    } gwel_mem_st_t;

    gwel_mem_st_t r;
    gwel_mem_st_t n;

    always_comb begin
        n = r;
        if (!bus.wr) begin
            n.rdata = (32'(bus.idx) < DEPTH) ? r.cells[bus.idx] : 8'h00;
        end
        if (bus.wr && 32'(bus.idx) < DEPTH) begin
            n.cells[bus.idx] = bus.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int s = 0; s < DEPTH; s++) begin
                // Named pins come up as outputs driving low; all use plain pin function
                r.cells[s] <= OUT_RST_MASK[s] ? CFG_RST_OUT : CFG_RST_IN;
            end
            r.rdata <= 8'h00;
        end else begin
            r <= n;
        end
    end

    assign bus.rdata = r.rdata;
    assign bus.cfg_all = r.cells;
endmodule

// [gwel_pin_env.sv]
// Far side of the pin bank: external sources meeting the block's drivers on each pin
`timescale 1ns/1ps
module gwel_pin_env (
    input wire logic [gwel_pkg::NSLOT-1:0] dev_out_i,
    input wire logic [gwel_pkg::NSLOT-1:0] dev_oe_i,
    input wire logic [gwel_pkg::NSLOT-1:0] ext_lvl_i,
    output logic [gwel_pkg::NSLOT-1:0] pin_lvl_o
);
    import gwel_pkg::*;
    // External sources are weak: a driving block pin always wins the wire
    assign pin_lvl_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & ext_lvl_i);
endmodule

// [gwel_pkg.sv]
// Constants, types and helper functions for the pin bank with wake, event and LED logic
// What this block does
// - Config bit0 direction, bit1 inversion, bit7 driver type
// - Direction 0 output, 1 input; inversion both ways
// - Driver type also governs alternate-function outputs
// - Inversion acts on alternates except listed exceptions
// - Joystick alternates are open-drain, never inverted
// - Input read returns latched pin; writes ignored
// - Output drives data bit; read returns last write
// - Output pins never set wake or interrupt status
// - Inversion picks wake edge; default rising edge
// - Wake needs status, own enable and global enable
// - Wake status clears only on write of one
// - Thirty-one pins own wake bits in four pairs
// - Nineteen pins own interrupt bits; third pair adds tach
// - Six pins set all statuses on either edge
// - Either-edge mode ignores config, read still inverted
// - Either-edge pin raises only when enabled and selected
// - Miscellaneous register gathers six either-edge bits, write-one-clear
// - Status bits record regardless of enables or mode
// - Three named pins reset as low outputs
// - Port4 pin3 resets to plain pin function
// - Two LED control registers at 0x5D, 0x5E
// - Standby blinking needs 32kHz clock, else none
// - Global wake status ignores global wake enable
package gwel_pkg;
    localparam int NSLOT = 48;
    localparam int MCLK_HZ = 10_000_000;
    localparam int K32_HZ = 32768;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = MCLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int BLINK_HALF_K32 = K32_HZ * BLINK_HALF_MS / 1000;

    // Host register offsets
    localparam logic [7:0] CFG_BASE = 8'h00;
    localparam logic [7:0] WSTS_BASE = 8'h30;
    localparam logic [7:0] WEN_BASE = 8'h34;
    localparam logic [7:0] WGSTS_OFF = 8'h38;
    localparam logic [7:0] WGEN_OFF = 8'h39;
    localparam logic [7:0] SSTS_BASE = 8'h3a;
    localparam logic [7:0] SEN_BASE = 8'h3d;
    localparam logic [7:0] MISC_OFF = 8'h40;
    localparam logic [7:0] DATA_BASE = 8'h4b;
    localparam logic [7:0] LED_A_OFF = 8'h5d;
    localparam logic [7:0] LED_B_OFF = 8'h5e;
    localparam int NWREG = 4;
    localparam int NSREG = 3;
    localparam int NDREG = 6;

    // Configuration field positions
    localparam int CFG_DIR = 0;
    localparam int CFG_POL = 1;
    localparam int CFG_FN_LO = 2;
    localparam int CFG_OD = 7;
    localparam logic [1:0] FN_GPIO = 2'h0;
    localparam logic [1:0] FN_ALT = 2'h1;
    localparam logic [1:0] FN_EITHER_EDGE_TRIGGER = 2'h3;

    // Reset values
    localparam logic [7:0] CFG_RST_IN = 8'h01;
    localparam logic [7:0] CFG_RST_OUT = 8'h00;
    localparam logic [NSLOT-1:0] OUT_RST_MASK = 48'h0008_000c_0000;
    localparam logic [7:0] LED_RST = 8'h00;

    // LED modes in control bits 1:0
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_BLINK = 2'h1;
    localparam logic [1:0] LED_ON = 2'h2;

    // Slot numbering: (port - 1) * 8 + bit
    localparam logic [5:0] SLOT_NONE = 6'h3f;
    localparam logic [5:0] SLOT_TACH_A = 6'h30;
    localparam logic [5:0] SLOT_TACH_B = 6'h31;
    localparam logic [5:0] SLOT_DRIVE_DENSITY_CTRL = 6'h1b;
    localparam logic [5:0] SLOT_JOY_LO = 6'h04;
    localparam logic [5:0] SLOT_JOY_HI = 6'h07;
    localparam logic [5:0] SLOT_LED_A = 6'h28;
    localparam logic [5:0] SLOT_LED_B = 6'h29;
    localparam logic [NSLOT-1:0] WAKE_CAP = 48'h03ff_0a0f_f7ff;
    localparam logic [NSLOT-1:0] SMI_CAP = 48'h03f0_0e0f_7700;
    localparam logic [NSLOT-1:0] EITHER_EDGE_TRIGGER_CAP = 48'h0300_0a00_0600;

    typedef logic [7:0][5:0] gwel_map_t;
    typedef logic [5:0][5:0] gwel_either_edge_trigger_list_t;

    localparam gwel_map_t [NWREG-1:0] WAKE_MAP = '{
        '{6'd39, 6'd38, 6'd37, 6'd36, 6'd35, 6'd34, 6'd33, 6'd32},
        '{6'd41, 6'd40, 6'd27, 6'd25, 6'd19, 6'd18, 6'd17, 6'd16},
        '{6'd15, 6'd14, 6'd13, 6'd12, SLOT_NONE, 6'd10, 6'd9, 6'd8},
        '{6'd7, 6'd6, 6'd5, 6'd4, 6'd3, 6'd2, 6'd1, 6'd0}};
    localparam gwel_map_t [NSREG-1:0] SMI_MAP = '{
        '{SLOT_NONE, SLOT_NONE, SLOT_TACH_B, SLOT_TACH_A, 6'd39, 6'd38, 6'd37, 6'd36},
        '{6'd41, 6'd27, 6'd26, 6'd25, 6'd19, 6'd18, 6'd17, 6'd16},
        '{SLOT_NONE, 6'd14, 6'd13, 6'd12, 6'd40, 6'd10, 6'd9, 6'd8}};
    localparam gwel_either_edge_trigger_list_t EITHER_EDGE_TRIGGER_SLOT = '{6'd41, 6'd40, 6'd27, 6'd25, 6'd10, 6'd9};

    function automatic logic [7:0] gwel_map_read(input logic [63:0] vec, input gwel_map_t m);
        logic [7:0] res;
        res = 8'h00;
        for (int b = 0; b < 8; b++) begin
            if (m[b] != SLOT_NONE) begin
                res[b] = vec[m[b]];
            end
        end
        return res;
    endfunction

    function automatic logic [63:0] gwel_map_mask(input gwel_map_t m, input logic [7:0] wd);
        logic [63:0] res;
        res = 64'h0;
        for (int b = 0; b < 8; b++) begin
            if (m[b] != SLOT_NONE && wd[b]) begin
                res[m[b]] = 1'b1;
            end
        end
        return res;
    endfunction

    function automatic logic [63:0] gwel_map_write(input logic [63:0] old, input gwel_map_t m,
                                                   input logic [7:0] wd);
        logic [63:0] res;
        res = old;
        for (int b = 0; b < 8; b++) begin
            if (m[b] != SLOT_NONE) begin
                res[m[b]] = wd[b];
            end
        end
        return res;
    endfunction
endpackage

// [gwel_port.sv]
// Pin bank: pin drive, data registers, wake and event status, LED blinking
`timescale 1ns/1ps
module gwel_port #(
    parameter int BLINK_CYC = gwel_pkg::BLINK_HALF_CYC,
    parameter int BLINK_K32 = gwel_pkg::BLINK_HALF_K32
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    input wire logic [gwel_pkg::NSLOT-1:0] pin_i,
    output logic [gwel_pkg::NSLOT-1:0] pin_o,
    output logic [gwel_pkg::NSLOT-1:0] pin_oe_o,
    input wire logic [gwel_pkg::NSLOT-1:0] alt_out_i,
    input wire logic [gwel_pkg::NSLOT-1:0] alt_oe_i,
    output logic [gwel_pkg::NSLOT-1:0] alt_in_o,
    input wire logic [1:0] fan_tach_i,
    input wire logic clk32k_i,
    input wire logic standby_i,
    output logic wake_event_o,
    output logic sysmgmt_event_o
);
    import gwel_pkg::*;

    typedef struct packed {
        logic [NSLOT-1:0] pin_s1;
        logic [NSLOT-1:0] pin_s2;
        logic [NSLOT-1:0] pin_prev;
        logic k32_s1;
        logic k32_s2;
        logic k32_prev;
        logic sby_s1;
        logic sby_s2;
        logic [NSLOT-1:0] data;
        logic [63:0] wsts;
        logic [63:0] wen;
        logic [63:0] ssts;
        logic [63:0] sen;
        logic [5:0] msts;
        logic wgsts;
        logic wgen;
        logic [7:0] led_a;
        logic [7:0] led_b;
        logic [23:0] bcnt;
        logic blink;
        logic cfg_rd;
        logic [5:0] cidx;
        logic [7:0] rdata;
        logic [NSLOT-1:0] pout;
        logic [NSLOT-1:0] poe;
        logic [NSLOT-1:0] ain;
    } gwel_st_t;

    gwel_st_t r;
    gwel_st_t n;
    gwel_cfg_if cfg ();

    gwel_cfg_mem #(
        .DEPTH(NSLOT)
    ) u_cfg (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .bus(cfg.mem)
    );

    logic [NSLOT-1:0] evt;
    logic [NSLOT-1:0] ee_sel;
    logic [63:0] wset;
    logic [63:0] wclr;
    logic [63:0] sset;
    logic [63:0] sclr;
    logic [5:0] mset;
    logic [5:0] mclr;
    logic [7:0] c;
    logic [7:0] rd;
    logic lvl;
    logic prv;
    logic pol;
    logic drv;
    logic val;
    logic odr;
    logic led_val;
    logic k32_tick;
    logic [23:0] blim;
    logic wr_cfg;

    function automatic logic led_level(input logic [7:0] ctrl, input logic blink);
        return (ctrl[1:0] == LED_ON) || (ctrl[1:0] == LED_BLINK && blink);
    endfunction

    assign wr_cfg = io_wr_i && io_addr_i < CFG_BASE + 8'(NSLOT);
    assign cfg.wr = wr_cfg;
    assign cfg.idx = (io_rd_i || wr_cfg) ? 6'(io_addr_i - CFG_BASE) : r.cidx;
    assign cfg.wdata = io_wdata_i;

    always_comb begin
        n = r;
        evt = '0;
        ee_sel = '0;
        wset = 64'h0;
        wclr = 64'h0;
        sset = 64'h0;
        sclr = 64'h0;
        mset = 6'h0;
        mclr = 6'h0;
        c = 8'h00;
        rd = 8'h00;
        lvl = 1'b0;
        prv = 1'b0;
        pol = 1'b0;
        drv = 1'b0;
        val = 1'b0;
        odr = 1'b0;
        led_val = 1'b0;

        // The second stage and the delayed copy after it feed the logic
        n.pin_s1 = pin_i;
        n.pin_s2 = r.pin_s1;
        n.pin_prev = r.pin_s2;
        n.k32_s1 = clk32k_i;
        n.k32_s2 = r.k32_s1;
        n.k32_prev = r.k32_s2;
        n.sby_s1 = standby_i;
        n.sby_s2 = r.sby_s1;

        // Blink timebase: under standby only the slow clock advances it, so no
        // slow clock means the LED holds its phase and does not blink
        k32_tick = r.k32_s2 && !r.k32_prev;
        blim = r.sby_s2 ? 24'(BLINK_K32 - 1) : 24'(BLINK_CYC - 1);
        if (!r.sby_s2 || k32_tick) begin
            if (r.bcnt >= blim) begin
                n.bcnt = 24'h0;
                n.blink = !r.blink;
            end else begin
                n.bcnt = r.bcnt + 24'h1;
            end
        end

        for (int s = 0; s < NSLOT; s++) begin
            c = cfg.cfg_all[s];
            pol = c[CFG_POL];
            lvl = r.pin_s2[s];
            prv = r.pin_prev[s];
            ee_sel[s] = EITHER_EDGE_TRIGGER_CAP[s] && c[CFG_FN_LO+:2] == FN_EITHER_EDGE_TRIGGER;
            if (ee_sel[s]) begin
                evt[s] = lvl ^ prv;
            end else begin
                // Inversion picks the edge; outputs take no part in events
                evt[s] = c[CFG_DIR] && ((lvl ^ pol) && !(prv ^ pol));
            end

            drv = 1'b0;
            val = 1'b0;
            odr = c[CFG_OD];
            n.ain[s] = lvl ^ pol;
            if (ee_sel[s]) begin
                drv = 1'b0;
                n.ain[s] = lvl;
            end else if (c[CFG_FN_LO+:2] == FN_ALT) begin
                if (s >= 32'(SLOT_JOY_LO) && s <= 32'(SLOT_JOY_HI)) begin
                    drv = alt_oe_i[s];
                    val = alt_out_i[s];
                    odr = 1'b1;
                    n.ain[s] = lvl;
                end else if (s == 32'(SLOT_DRIVE_DENSITY_CTRL)) begin
                    drv = alt_oe_i[s];
                    val = alt_out_i[s];
                    n.ain[s] = lvl;
                end else if (s == 32'(SLOT_LED_A) || s == 32'(SLOT_LED_B)) begin
                    led_val = (s == 32'(SLOT_LED_A)) ? led_level(r.led_a, r.blink)
                                                      : led_level(r.led_b, r.blink);
                    drv = 1'b1;
                    val = led_val ^ pol;
                end else begin
                    drv = alt_oe_i[s];
                    val = alt_out_i[s] ^ pol;
                end
            end else begin
                drv = !c[CFG_DIR];
                val = r.data[s] ^ pol;
            end
            // An open-drain driver only ever sinks
            n.pout[s] = val;
            n.poe[s] = drv && (!odr || !val);
        end

        wset[NSLOT-1:0] = evt & WAKE_CAP;
        sset[NSLOT-1:0] = evt & SMI_CAP;
        sset[SLOT_TACH_A] = fan_tach_i[0];
        sset[SLOT_TACH_B] = fan_tach_i[1];
        for (int i = 0; i < 6; i++) begin
            mset[i] = evt[EITHER_EDGE_TRIGGER_SLOT[i]];
        end

        if (io_wr_i) begin
            for (int k = 0; k < NWREG; k++) begin
                if (io_addr_i == WSTS_BASE + 8'(k)) begin
                    wclr = gwel_map_mask(WAKE_MAP[k], io_wdata_i);
                end
                if (io_addr_i == WEN_BASE + 8'(k)) begin
                    n.wen = gwel_map_write(r.wen, WAKE_MAP[k], io_wdata_i);
                end
            end
            for (int k = 0; k < NSREG; k++) begin
                if (io_addr_i == SSTS_BASE + 8'(k)) begin
                    sclr = gwel_map_mask(SMI_MAP[k], io_wdata_i);
                end
                if (io_addr_i == SEN_BASE + 8'(k)) begin
                    n.sen = gwel_map_write(r.sen, SMI_MAP[k], io_wdata_i);
                end
            end
            for (int p = 0; p < NDREG; p++) begin
                if (io_addr_i == DATA_BASE + 8'(p)) begin
                    for (int b = 0; b < 8; b++) begin
                        c = cfg.cfg_all[p*8+b];
                        // Writes to inputs change nothing
                        if (!c[CFG_DIR] && !ee_sel[p*8+b]) begin
                            n.data[p*8+b] = io_wdata_i[b];
                        end
                    end
                end
            end
            if (io_addr_i == MISC_OFF) begin
                mclr = io_wdata_i[5:0];
            end
            if (io_addr_i == WGEN_OFF) begin
                n.wgen = io_wdata_i[0];
            end
            if (io_addr_i == LED_A_OFF) begin
                n.led_a = io_wdata_i;
            end
            if (io_addr_i == LED_B_OFF) begin
                n.led_b = io_wdata_i;
            end
        end

        // A new event beats a clear in the same cycle
        n.wsts = (r.wsts & ~wclr) | wset;
        n.ssts = (r.ssts & ~sclr) | sset;
        n.msts = (r.msts & ~mclr) | mset;
        // Global wake status follows enabled wake sources only and cannot be
        // cleared while one of them is still pending
        if (|(r.wsts & r.wen)) begin
            n.wgsts = 1'b1;
        end else if (io_wr_i && io_addr_i == WGSTS_OFF && io_wdata_i[0]) begin
            n.wgsts = 1'b0;
        end

        if (io_rd_i) begin
            n.cfg_rd = io_addr_i < CFG_BASE + 8'(NSLOT);
            n.cidx = 6'(io_addr_i - CFG_BASE);
            rd = 8'h00;
            for (int k = 0; k < NWREG; k++) begin
                if (io_addr_i == WSTS_BASE + 8'(k)) begin
                    rd = gwel_map_read(r.wsts, WAKE_MAP[k]);
                end
                if (io_addr_i == WEN_BASE + 8'(k)) begin
                    rd = gwel_map_read(r.wen, WAKE_MAP[k]);
                end
            end
            for (int k = 0; k < NSREG; k++) begin
                if (io_addr_i == SSTS_BASE + 8'(k)) begin
                    rd = gwel_map_read(r.ssts, SMI_MAP[k]);
                end
                if (io_addr_i == SEN_BASE + 8'(k)) begin
                    rd = gwel_map_read(r.sen, SMI_MAP[k]);
                end
            end
            for (int p = 0; p < NDREG; p++) begin
                if (io_addr_i == DATA_BASE + 8'(p)) begin
                    for (int b = 0; b < 8; b++) begin
                        c = cfg.cfg_all[p*8+b];
                        if (c[CFG_DIR] || ee_sel[p*8+b]) begin
                            rd[b] = r.pin_s2[p*8+b] ^ c[CFG_POL];
                        end else begin
                            rd[b] = r.data[p*8+b];
                        end
                    end
                end
            end
            if (io_addr_i == MISC_OFF) begin
                rd = {2'b00, r.msts};
            end
            if (io_addr_i == WGSTS_OFF) begin
                rd = {7'h00, r.wgsts};
            end
            if (io_addr_i == WGEN_OFF) begin
                rd = {7'h00, r.wgen};
            end
            if (io_addr_i == LED_A_OFF) begin
                rd = r.led_a;
            end
            if (io_addr_i == LED_B_OFF) begin
                rd = r.led_b;
            end
            n.rdata = rd;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            r <= '0;
            r.led_a <= LED_RST;
            r.led_b <= LED_RST;
        end else begin
            r <= n;
        end
    end

    assign io_rdata_o = r.cfg_rd ? cfg.rdata : r.rdata;
    assign pin_o = r.pout;
    assign pin_oe_o = r.poe;
    assign alt_in_o = r.ain;
    assign wake_event_o = r.wgen && |(r.wsts & r.wen);
    assign sysmgmt_event_o = |(r.ssts & r.sen);
endmodule

// [gwel_port_monitor.sv]
// Port-level checker for the pin bank, bound into gwel_port
`timescale 1ns/1ps
module gwel_port_monitor (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic [gwel_pkg::NSLOT-1:0] pin_i,
    input wire logic [gwel_pkg::NSLOT-1:0] pin_o,
    input wire logic [gwel_pkg::NSLOT-1:0] pin_oe_o,
    input wire logic [gwel_pkg::NSLOT-1:0] alt_out_i,
    input wire logic [gwel_pkg::NSLOT-1:0] alt_oe_i,
    input wire logic [gwel_pkg::NSLOT-1:0] alt_in_o,
    input wire logic [1:0] fan_tach_i,
    input wire logic wake_event_o,
    input wire logic sysmgmt_event_o
);
    import gwel_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Cycles since reset release; the first few carry the reset pipeline settling
    logic [3:0] age_r;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            age_r <= 4'h0;
        end else if (age_r != 4'hf) begin
            age_r <= age_r + 4'h1;
        end
    end
    chk_reset_low_out: assert property ($fell(rst_i) |-> io_rdata_o == 8'h00 ##2
        ((pin_oe_o & OUT_RST_MASK) == OUT_RST_MASK && (pin_o & OUT_RST_MASK) == '0))
        else $error("reset pin state wrong");
    chk_rdata_holds: assert property ($changed(io_rdata_o) |-> $past(io_rd_i))
        else $error("read data moved without a read");
    chk_unmapped_zero: assert property (io_rd_i && io_addr_i > 8'h5e |=> io_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_pins_by_write: assert property ($changed({pin_o[39:0], pin_oe_o[39:0]}) |->
        age_r < 4'h5 || $past(io_wr_i) || $past(io_wr_i, 2) || $past(io_wr_i, 3)
        || $past(alt_out_i) != $past(alt_out_i, 3) || $past(alt_oe_i) != $past(alt_oe_i, 3))
        else $error("pin drive changed without cause");
    chk_wake_rise_cause: assert property ($rose(wake_event_o) |->
        $past(io_wr_i) || $past(io_wr_i, 2) || $past(pin_i, 2) != $past(pin_i, 6))
        else $error("wake event rose without cause");
    chk_smi_rise_cause: assert property ($rose(sysmgmt_event_o) |->
        $past(io_wr_i) || $past(io_wr_i, 2) || $past(pin_i, 2) != $past(pin_i, 6)
        || $past(fan_tach_i) != 2'h0)
        else $error("interrupt event rose without cause");
    chk_wake_fall_write: assert property ($fell(wake_event_o) |->
        $past(io_wr_i) || $past(io_wr_i, 2))
        else $error("wake event dropped without a write");
    chk_smi_fall_write: assert property ($fell(sysmgmt_event_o) |->
        $past(io_wr_i) || $past(io_wr_i, 2))
        else $error("interrupt event dropped without a write");
    chk_joystick_plain: assert property (($stable(pin_i[4]) && age_r == 4'hf) [*4] |->
        alt_in_o[4] == pin_i[4])
        else $error("joystick input inverted or stale");
endmodule

bind gwel_port gwel_port_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i),
    .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_rdata_o(io_rdata_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .alt_out_i(alt_out_i),
    .alt_oe_i(alt_oe_i), .alt_in_o(alt_in_o), .fan_tach_i(fan_tach_i),
    .wake_event_o(wake_event_o), .sysmgmt_event_o(sysmgmt_event_o));

// [gwel_tb.sv]
// Self-checking bench for the pin bank: registers, pin drive, events and LEDs
`timescale 1ns/1ps
module tb;
    import gwel_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] io_addr_i = 8'h00;
    logic io_wr_i = 1'b0;
    logic io_rd_i = 1'b0;
    logic [7:0] io_wdata_i = 8'h00;
    logic [7:0] io_rdata_o;
    logic [NSLOT-1:0] pin_i, pin_o, pin_oe_o, alt_in_o;
    logic [NSLOT-1:0] ext_lvl = '0;
    logic [NSLOT-1:0] alt_out_i = '0;
    logic [NSLOT-1:0] alt_oe_i = '0;
    logic clk32k_i = 1'b0;
    logic standby_i = 1'b0;
    logic run32k = 1'b0;
    logic [1:0] fan_tach_i = 2'h0;
    logic wake_event_o, sysmgmt_event_o;
    logic [15:0] ones_tab [7];
    int miscompares = 0;
    int checked = 0;
    int n;

    always #50 mclk_i = ~mclk_i;
    always begin
        repeat (15) @(posedge mclk_i);
        #5;
        if (run32k) clk32k_i = ~clk32k_i;
    end

    gwel_port #(.BLINK_CYC(8), .BLINK_K32(4)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
        .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i),
        .alt_in_o(alt_in_o), .fan_tach_i(fan_tach_i), .clk32k_i(clk32k_i),
        .standby_i(standby_i), .wake_event_o(wake_event_o),
        .sysmgmt_event_o(sysmgmt_event_o));
    gwel_pin_env env (.dev_out_i(pin_o), .dev_oe_i(pin_oe_o), .ext_lvl_i(ext_lvl),
        .pin_lvl_o(pin_i));

    task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmpb(input logic got, input logic exp);
        cmp({47'h0, got}, {47'h0, exp});
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk_i);
        #5;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #5;
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1'b1;
        tick(1);
        io_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        #5;
        io_addr_i = a;
        io_rd_i = 1'b1;
        tick(1);
        io_rd_i = 1'b0;
        cmp({40'h0, io_rdata_o}, {40'h0, exp});
    endtask
    task automatic toggles(input int idx, input int cyc, output int cnt);
        logic last;
        last = pin_o[idx];
        cnt = 0;
        repeat (cyc) begin
            tick(1);
            if (pin_o[idx] !== last) cnt++;
            last = pin_o[idx];
        end
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        miscompares++;
        tally_and_finish();
    end

    initial begin
        ones_tab = '{{WEN_BASE, 8'hff}, {WEN_BASE + 8'h1, 8'hf7}, {WEN_BASE + 8'h2, 8'hff},
            {WEN_BASE + 8'h3, 8'hff}, {SEN_BASE, 8'h7f}, {SEN_BASE + 8'h1, 8'hff},
            {SEN_BASE + 8'h2, 8'h3f}};
        repeat (12) @(posedge mclk_i);
        #5;
        rst_i = 1'b0;
        tick(4);
        cmp(pin_oe_o & OUT_RST_MASK, OUT_RST_MASK);
        cmp(pin_o & OUT_RST_MASK, 48'h0);
        rd(CFG_BASE + 8'h12, CFG_RST_OUT);
        rd(CFG_BASE + 8'h1b, CFG_RST_IN);
        rd(LED_A_OFF, LED_RST);
        rd(8'h60, 8'h00);
        // Enable bit count per register shows which pins own event bits
        for (int i = 0; i < 7; i++) begin
            wr(ones_tab[i][15:8], 8'hff);
            rd(ones_tab[i][15:8], ones_tab[i][7:0]);
            wr(ones_tab[i][15:8], 8'h00);
        end
        // Output pin: drive, inversion, open drain, event exclusion
        wr(DATA_BASE + 8'h2, 8'h04);
        tick(2);
        cmpb(pin_o[18] & pin_oe_o[18], 1'b1);
        rd(DATA_BASE + 8'h2, 8'h04);
        rd(WSTS_BASE + 8'h2, 8'h00);
        wr(CFG_BASE + 8'h12, 8'h02);
        tick(2);
        cmpb(pin_o[18], 1'b0);
        rd(DATA_BASE + 8'h2, 8'h04);
        wr(CFG_BASE + 8'h12, 8'h80);
        tick(2);
        cmpb(pin_oe_o[18], 1'b0);
        wr(DATA_BASE + 8'h2, 8'h00);
        tick(2);
        cmpb(pin_oe_o[18] & ~pin_o[18], 1'b1);
        // Input pin: read-back, ignored writes, wake edge and clearing
        ext_lvl[0] = 1'b1;
        tick(5);
        wr(DATA_BASE, 8'h00);
        rd(DATA_BASE, 8'h01);
        rd(WSTS_BASE, 8'h01);
        wr(WSTS_BASE, 8'h00);
        rd(WSTS_BASE, 8'h01);
        wr(WSTS_BASE, 8'h01);
        rd(WSTS_BASE, 8'h00);
        wr(CFG_BASE, 8'h03);
        rd(DATA_BASE, 8'h00);
        cmpb(alt_in_o[0], 1'b0);
        ext_lvl[0] = 1'b0;
        tick(5);
        rd(WSTS_BASE, 8'h01);
        cmpb(wake_event_o, 1'b0);
        wr(WEN_BASE, 8'h01);
        tick(2);
        cmpb(wake_event_o, 1'b0);
        rd(WGSTS_OFF, 8'h01);
        wr(WGEN_OFF, 8'h01);
        tick(1);
        cmpb(wake_event_o, 1'b1);
        wr(WSTS_BASE, 8'h01);
        tick(1);
        cmpb(wake_event_o, 1'b0);
        // Either-edge pin: both edges, shared status, enable gating
        wr(CFG_BASE + 8'h09, 8'h0c);
        tick(2);
        cmpb(pin_oe_o[9], 1'b0);
        ext_lvl[9] = 1'b1;
        tick(5);
        rd(MISC_OFF, 8'h01);
        rd(WSTS_BASE + 8'h1, 8'h02);
        rd(SSTS_BASE, 8'h02);
        cmpb(sysmgmt_event_o, 1'b0);
        wr(SEN_BASE, 8'h02);
        tick(1);
        cmpb(sysmgmt_event_o, 1'b1);
        wr(MISC_OFF, 8'h3f);
        wr(SSTS_BASE, 8'hff);
        wr(WSTS_BASE + 8'h1, 8'hff);
        rd(MISC_OFF, 8'h00);
        cmpb(sysmgmt_event_o, 1'b0);
        ext_lvl[9] = 1'b0;
        tick(5);
        rd(MISC_OFF, 8'h01);
        cmpb(sysmgmt_event_o, 1'b1);
        wr(CFG_BASE + 8'h09, 8'h0e);
        rd(DATA_BASE + 8'h1, 8'h02);
        wr(SEN_BASE, 8'h00);
        fan_tach_i = 2'h1;
        tick(1);
        fan_tach_i = 2'h0;
        rd(SSTS_BASE + 8'h2, 8'h10);
        // Joystick alternate: open drain, never inverted
        wr(CFG_BASE + 8'h04, 8'h07);
        alt_oe_i[4] = 1'b1;
        alt_out_i[4] = 1'b1;
        ext_lvl[4] = 1'b1;
        tick(6);
        cmpb(pin_oe_o[4], 1'b0);
        cmpb(alt_in_o[4], 1'b1);
        alt_out_i[4] = 1'b0;
        tick(3);
        cmpb(pin_oe_o[4] & ~pin_o[4], 1'b1);
        // LED pins: on, off, independent blinking, standby slow clock
        wr(CFG_BASE + 8'h28, 8'h04);
        wr(CFG_BASE + 8'h29, 8'h04);
        wr(LED_A_OFF, {6'h0, LED_ON});
        tick(3);
        cmpb(pin_o[40] & pin_oe_o[40], 1'b1);
        wr(LED_A_OFF, {6'h0, LED_OFF});
        tick(3);
        cmpb(pin_o[40], 1'b0);
        wr(LED_B_OFF, {6'h0, LED_ON});
        rd(LED_B_OFF, {6'h0, LED_ON});
        wr(LED_A_OFF, {6'h0, LED_BLINK});
        toggles(40, 40, n);
        cmpb(n >= 3, 1'b1);
        cmpb(pin_o[41], 1'b1);
        standby_i = 1'b1;
        tick(6);
        toggles(40, 60, n);
        cmpb(n == 0, 1'b1);
        run32k = 1'b1;
        toggles(40, 600, n);
        cmpb(n >= 2, 1'b1);
        tally_and_finish();
    end
endmodule
